/* rtl/aaso_pkg.sv */
`default_nettype none
package aaso_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CMD       = 8'h00;
   localparam logic [7:0] OFS_ACC       = 8'h04;
   localparam logic [7:0] OFS_STATUS    = 8'h08;
   localparam logic [7:0] OFS_PTR0      = 8'h0C;
   localparam logic [7:0] OFS_PTR1      = 8'h10;
   localparam logic [7:0] OFS_FILE_SEL  = 8'h14;
   localparam logic [7:0] OFS_FILE_DATA = 8'h18;

   // Command word fields
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_OP_W     = 3;
   localparam int CMD_DEST_BIT = 4;
   localparam int CMD_PSEL_BIT = 5;
   localparam int CMD_FA_LSB   = 8;
   localparam int CMD_LIT_LSB  = 16;

   // Status flag positions
   localparam int FLG_C    = 0;
   localparam int FLG_DIGC = 1;
   localparam int FLG_Z    = 2;
   localparam int FLG_W    = 3;

   // Datapath widths
   localparam int DATA_W = 8;
   localparam int PTR_W  = 16;
   localparam int PLIT_W = 6;
   localparam int NIB_W  = 4;
   localparam int FA_W   = 7;

   // Reset values
   localparam logic [7:0]  ACC_RST = 8'h00;
   localparam logic [2:0]  FLG_RST = 3'h0;
   localparam logic [15:0] PTR_RST = 16'h0000;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Operations, in command code order 0..7
   typedef enum logic [2:0] {
      OP_NOP,
      OP_PTR_ADD,
      OP_AND_IMM,
      OP_ADD_IMM,
      OP_AND_FILE,
      OP_ADD_FILE,
      OP_ASR_FILE,
      OP_ADC_FILE
   } aaso_op_t;

endpackage
`default_nettype wire

/* rtl/aaso_alu.sv */
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module aaso_alu #(
   parameter int ADDR_W     = 8,
   parameter int FILE_DEPTH = 128
) (
   input  wire logic              clk_sys,
   input  wire logic              reset,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   localparam int DW = aaso_pkg::DATA_W;
   localparam int PW = aaso_pkg::PTR_W;
   localparam int LW = aaso_pkg::PLIT_W;
   localparam int NW = aaso_pkg::NIB_W;
   localparam int FW = aaso_pkg::FA_W;

   // Bus-side state
   logic              aw_held_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic              w_held_ff;
   logic [31:0]       wdata_ff;
   logic [3:0]        wstrb_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              rvalid_ff;
   logic [1:0]        rresp_ff;
   logic [31:0]       rdata_ff;

   // Block state
   logic [31:0]     cmd_ff;
   logic [DW-1:0]   acc_ff;
   logic            c_ff;
   logic            digc_ff;
   logic            z_ff;
   logic [PW-1:0]   ptr_ff [2];
   logic [FW-1:0]   fsel_ff;
   logic [DW-1:0]   file_mem [FILE_DEPTH];

   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] aaso_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Handshakes; nothing moves while frozen
   assign s_axi_awready = ce & ~aw_held_ff & ~bvalid_ff;
   assign s_axi_wready  = ce & ~w_held_ff & ~bvalid_ff;
   assign s_axi_arready = ce & ~rvalid_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_rdata   = rdata_ff;

   wire do_write = ce & aw_held_ff & w_held_ff & ~bvalid_ff;
   wire do_read  = s_axi_arvalid & s_axi_arready;

   // Write address decode
   wire [7:0] wa = 8'(awaddr_ff);
   wire wr_cmd  = do_write & (wa == aaso_pkg::OFS_CMD);
   wire wr_acc  = do_write & (wa == aaso_pkg::OFS_ACC);
   wire wr_stat = do_write & (wa == aaso_pkg::OFS_STATUS);
   wire wr_p0   = do_write & (wa == aaso_pkg::OFS_PTR0);
   wire wr_p1   = do_write & (wa == aaso_pkg::OFS_PTR1);
   wire wr_fsel = do_write & (wa == aaso_pkg::OFS_FILE_SEL);
   wire wr_fdat = do_write & (wa == aaso_pkg::OFS_FILE_DATA);
   wire wr_hit  = wr_cmd | wr_acc | wr_stat | wr_p0 | wr_p1
                  | wr_fsel | wr_fdat;

   // Command decode from the merged command word
   wire [31:0] cmd_w = aaso_merge(cmd_ff, wdata_ff, wstrb_ff);
   wire aaso_pkg::aaso_op_t op =
      aaso_pkg::aaso_op_t'(cmd_w[aaso_pkg::CMD_OP_LSB +: aaso_pkg::CMD_OP_W]);
   wire          dest_f = cmd_w[aaso_pkg::CMD_DEST_BIT];
   wire          psel   = cmd_w[aaso_pkg::CMD_PSEL_BIT];
   wire [FW-1:0] faddr  = cmd_w[aaso_pkg::CMD_FA_LSB +: FW];
   wire [DW-1:0] lit    = cmd_w[aaso_pkg::CMD_LIT_LSB +: DW];
   wire [DW-1:0] fval   = file_mem[faddr];

   wire is_imm  = (op == aaso_pkg::OP_AND_IMM) | (op == aaso_pkg::OP_ADD_IMM);
   wire is_and  = (op == aaso_pkg::OP_AND_IMM) | (op == aaso_pkg::OP_AND_FILE);
   wire is_add  = (op == aaso_pkg::OP_ADD_IMM) | (op == aaso_pkg::OP_ADD_FILE)
                  | (op == aaso_pkg::OP_ADC_FILE);
   wire is_asr  = (op == aaso_pkg::OP_ASR_FILE);
   wire is_file = (op == aaso_pkg::OP_AND_FILE) | (op == aaso_pkg::OP_ADD_FILE)
                  | is_asr | (op == aaso_pkg::OP_ADC_FILE);
   wire is_ptr  = (op == aaso_pkg::OP_PTR_ADD);
   wire exec    = wr_cmd & (op != aaso_pkg::OP_NOP);

   // Arithmetic and logic results
   wire [DW-1:0] opnd = is_imm ? lit : fval;
   wire          cin  = (op == aaso_pkg::OP_ADC_FILE) & c_ff;
   wire [DW:0]   sum9 = {1'b0, acc_ff} + {1'b0, opnd} + {{DW{1'b0}}, cin};
   wire [NW:0]   nib  = {1'b0, acc_ff[NW-1:0]} + {1'b0, opnd[NW-1:0]}
                        + {{NW{1'b0}}, cin};
   wire [DW-1:0] and_r = acc_ff & opnd;
   wire [DW-1:0] asr_r = {fval[DW-1], fval[DW-1:1]};
   wire [DW-1:0] res = is_and ? and_r : (is_asr ? asr_r : sum9[DW-1:0]);

   // Flag results
   wire res_zero = (res == '0);
   wire nxt_c    = is_asr ? fval[0] : (is_add ? sum9[DW] : c_ff);
   wire nxt_digc = is_add ? nib[NW] : digc_ff;
   wire upd_z    = is_and | is_add | is_asr;

   // Destination steering
   wire to_file = exec & is_file & dest_f;
   wire to_acc  = exec & (is_imm | (is_file & ~dest_f));

   // Pointer add, 16-bit wrap
   wire [PW-1:0] plit = {{(PW-LW){lit[LW-1]}}, lit[LW-1:0]};
   wire [PW-1:0] nxt_ptr = ptr_ff[psel] + plit;

   // Write channel capture
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
      end else if (ce) begin
         if (s_axi_awvalid & s_axi_awready) aw_held_ff <= 1'b1;
         else if (do_write) aw_held_ff <= 1'b0;
         if (s_axi_wvalid & s_axi_wready) w_held_ff <= 1'b1;
         else if (do_write) w_held_ff <= 1'b0;
         if (do_write) bvalid_ff <= 1'b1;
         else if (s_axi_bready) bvalid_ff <= 1'b0;
      end
   end

   // Write payload and response code
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         awaddr_ff <= '0;
         wdata_ff  <= 32'h0;
         wstrb_ff  <= 4'h0;
         bresp_ff  <= aaso_pkg::RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid & s_axi_awready) awaddr_ff <= s_axi_awaddr;
         if (s_axi_wvalid & s_axi_wready) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (do_write)
            bresp_ff <= wr_hit ? aaso_pkg::RESP_OKAY : aaso_pkg::RESP_SLVERR;
      end
   end

   // Command word and file selector
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cmd_ff  <= 32'h0;
         fsel_ff <= '0;
      end else if (ce) begin
         if (wr_cmd) cmd_ff <= cmd_w;
         if (wr_fsel) fsel_ff <= wdata_ff[FW-1:0];
      end
   end

   // Accumulator
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         acc_ff <= aaso_pkg::ACC_RST;
      end else if (ce) begin
         if (to_acc) acc_ff <= res;
         else if (wr_acc) acc_ff <= wdata_ff[DW-1:0];
      end
   end

   // Status flags; pointer add leaves them alone
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         {z_ff, digc_ff, c_ff} <= aaso_pkg::FLG_RST;
      end else if (ce) begin
         if (exec & ~is_ptr) begin
            c_ff    <= nxt_c;
            digc_ff <= nxt_digc;
            if (upd_z) z_ff <= res_zero;
         end else if (wr_stat) begin
            c_ff    <= wdata_ff[aaso_pkg::FLG_C];
            digc_ff <= wdata_ff[aaso_pkg::FLG_DIGC];
            z_ff    <= wdata_ff[aaso_pkg::FLG_Z];
         end
      end
   end

   // Indirect pointers, one per generate entry
   for (genvar g = 0; g < 2; g++) begin : g_ptr
      wire sw_wr = (g == 0) ? wr_p0 : wr_p1;
      always_ff @(posedge clk_sys) begin
         if (reset) begin
            ptr_ff[g] <= aaso_pkg::PTR_RST;
         end else if (ce) begin
            if (exec & is_ptr & (psel == 1'(g))) ptr_ff[g] <= nxt_ptr;
            else if (sw_wr) ptr_ff[g] <= wdata_ff[PW-1:0];
         end
      end
   end

   // File register storage
   always_ff @(posedge clk_sys) begin
      if (ce) begin
         if (to_file) file_mem[faddr] <= res;
         else if (wr_fdat) file_mem[fsel_ff] <= wdata_ff[DW-1:0];
      end
   end

   // Read address decode
   wire [7:0] ra = 8'(s_axi_araddr);
   logic [31:0] rd_mux;
   logic        rd_hit;
   always_comb begin
      rd_mux = 32'h0;
      rd_hit = 1'b1;
      if (ra == aaso_pkg::OFS_CMD) rd_mux = cmd_ff;
      else if (ra == aaso_pkg::OFS_ACC) rd_mux = 32'(acc_ff);
      else if (ra == aaso_pkg::OFS_STATUS) rd_mux = 32'({z_ff, digc_ff, c_ff});
      else if (ra == aaso_pkg::OFS_PTR0) rd_mux = 32'(ptr_ff[0]);
      else if (ra == aaso_pkg::OFS_PTR1) rd_mux = 32'(ptr_ff[1]);
      else if (ra == aaso_pkg::OFS_FILE_SEL) rd_mux = 32'(fsel_ff);
      else if (ra == aaso_pkg::OFS_FILE_DATA) rd_mux = 32'(file_mem[fsel_ff]);
      else rd_hit = 1'b0;
   end

   // Read channel
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0;
         rresp_ff  <= aaso_pkg::RESP_OKAY;
      end else if (ce) begin
         if (do_read) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
            rresp_ff  <= rd_hit ? aaso_pkg::RESP_OKAY : aaso_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // Checks on the datapath, sampled one edge after execution
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   wire [PW-1:0] exp_ptr = nxt_ptr;
   wire [DW-1:0] src_f   = fval;

   a_ptr_add_value: assert property (exec & is_ptr |=>
      ptr_ff[$past(psel)] == $past(exp_ptr)) else $error("pointer add wrong");
   a_ptr_flags_kept: assert property (exec & is_ptr |=>
      $stable({c_ff, digc_ff, z_ff})) else $error("pointer add moved flags");
   a_and_imm_only_z: assert property (
      exec & (op == aaso_pkg::OP_AND_IMM) |=> $stable(c_ff) && $stable(digc_ff)
      && acc_ff == ($past(acc_ff) & $past(lit))) else $error("and imm wrong");
   a_add_imm_sum: assert property (
      exec & (op == aaso_pkg::OP_ADD_IMM) |=>
      {c_ff, acc_ff} == $past(acc_ff) + $past(lit)) else $error("add imm wrong");
   a_and_file_z: assert property (
      exec & (op == aaso_pkg::OP_AND_FILE) |=> $stable(c_ff)
      && z_ff == (($past(acc_ff) & $past(src_f)) == 0))
      else $error("and file flags wrong");
   a_dest_acc_kept: assert property (exec & is_file & dest_f |=>
      $stable(acc_ff)) else $error("file dest touched accumulator");
   a_asr_carry: assert property (exec & is_asr |=>
      c_ff == $past(src_f[0])) else $error("shift carry wrong");
   a_asr_sign_kept: assert property (exec & is_asr & ~dest_f |=>
      acc_ff[7] == $past(src_f[7]) && acc_ff[6:0] == $past(src_f[7:1]))
      else $error("shift sign lost");
   a_adc_carry_in: assert property (
      exec & (op == aaso_pkg::OP_ADC_FILE) & ~dest_f |=>
      {c_ff, acc_ff} == $past(acc_ff) + $past(src_f) + $past(c_ff))
      else $error("add with carry wrong");
   a_zero_flag: assert property (exec & upd_z & ~dest_f |=>
      z_ff == (acc_ff == 0)) else $error("zero flag wrong");
   a_digc_nibble: assert property (exec & is_add |=>
      digc_ff == (({1'b0, $past(acc_ff[3:0])} + $past(opnd[3:0])
      + $past(cin)) > 5'h0F)) else $error("digit carry wrong");

   c_ptr_wrap: cover property (exec & is_ptr & (nxt_ptr < ptr_ff[psel])
      & ~lit[LW-1]);
   c_adc_file: cover property (exec & (op == aaso_pkg::OP_ADC_FILE) & c_ff);
   c_asr_neg: cover property (exec & is_asr & fval[DW-1] & fval[0]);

endmodule
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic [7:0]  acc;
      logic [2:0]  flg;
      logic [7:0]  fv;
      logic [31:0] cmd;
      logic [7:0]  eacc;
      logic [2:0]  eflg;
      logic [7:0]  efile;
   } aaso_row_t;

   logic        clk_sys = 1'b0;
   logic        reset   = 1'b1;
   logic        ce      = 1'b1;
   logic [7:0]  awaddr  = 8'h00;
   logic        awvalid = 1'b0;
   logic        awready;
   logic [31:0] wdata   = 32'h00000000;
   logic [3:0]  wstrb   = 4'hF;
   logic        wvalid  = 1'b0;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready  = 1'b0;
   logic [7:0]  araddr  = 8'h00;
   logic        arvalid = 1'b0;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready  = 1'b0;
   int          mismatches = 0;
   int          checked    = 0;
   int          cycles     = 0;
   aaso_row_t   rows [16];

   aaso_alu aaso_alu_i (
      .clk_sys       (clk_sys),
      .reset         (reset),
      .ce            (ce),
      .s_axi_awaddr  (awaddr),
      .s_axi_awvalid (awvalid),
      .s_axi_awready (awready),
      .s_axi_wdata   (wdata),
      .s_axi_wstrb   (wstrb),
      .s_axi_wvalid  (wvalid),
      .s_axi_wready  (wready),
      .s_axi_bresp   (bresp),
      .s_axi_bvalid  (bvalid),
      .s_axi_bready  (bready),
      .s_axi_araddr  (araddr),
      .s_axi_arvalid (arvalid),
      .s_axi_arready (arready),
      .s_axi_rdata   (rdata),
      .s_axi_rresp   (rresp),
      .s_axi_rvalid  (rvalid),
      .s_axi_rready  (rready)
   );

   // Clock and hang guard
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Write with address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bready && bvalid) begin
            chk({30'h0, bresp}, {30'h0, er});
            break;
         end
      end
   endtask

   // Read and compare data and response
   task automatic rdx(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rready && rvalid) begin
            chk(rdata, e);
            chk({30'h0, rresp}, {30'h0, er});
            break;
         end
      end
   endtask

   task automatic do_reset();
      reset <= 1'b1;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
   endtask

   localparam logic [1:0] OK = aaso_pkg::RESP_OKAY;
   localparam logic [1:0] ER = aaso_pkg::RESP_SLVERR;

   initial begin
      rows = '{
         '{8'h55, 3'h7, 8'h11, 32'h00000000, 8'h55, 3'h7, 8'h11},
         '{8'hF0, 3'h3, 8'h11, 32'h000F0002, 8'h00, 3'h7, 8'h11},
         '{8'h0F, 3'h0, 8'h11, 32'h00010003, 8'h10, 3'h2, 8'h11},
         '{8'hFF, 3'h0, 8'h11, 32'h00010003, 8'h00, 3'h7, 8'h11},
         '{8'h7F, 3'h1, 8'h11, 32'h00800003, 8'hFF, 3'h0, 8'h11},
         '{8'h3C, 3'h3, 8'hF0, 32'h00000504, 8'h30, 3'h3, 8'hF0},
         '{8'h3C, 3'h0, 8'h03, 32'h00000514, 8'h3C, 3'h4, 8'h00},
         '{8'h80, 3'h0, 8'h80, 32'h00000505, 8'h00, 3'h5, 8'h80},
         '{8'h01, 3'h1, 8'h01, 32'h00000505, 8'h02, 3'h0, 8'h01},
         '{8'h08, 3'h0, 8'h08, 32'h00000515, 8'h08, 3'h2, 8'h10},
         '{8'h00, 3'h2, 8'h81, 32'h00000506, 8'hC0, 3'h3, 8'h81},
         '{8'h00, 3'h0, 8'h01, 32'h00000516, 8'h00, 3'h5, 8'h00},
         '{8'h00, 3'h1, 8'h7E, 32'h00000506, 8'h3F, 3'h0, 8'h7E},
         '{8'h0F, 3'h1, 8'h00, 32'h00000507, 8'h10, 3'h2, 8'h00},
         '{8'hFF, 3'h1, 8'h00, 32'h00000517, 8'hFF, 3'h7, 8'h00},
         '{8'h01, 3'h0, 8'h02, 32'h00000507, 8'h03, 3'h0, 8'h02}};
      do_reset();
      // Values after reset
      rdx(aaso_pkg::OFS_ACC, 32'h0, OK);
      rdx(aaso_pkg::OFS_STATUS, 32'h0, OK);
      rdx(aaso_pkg::OFS_PTR0, 32'h0, OK);
      // Table of operations on file register 5
      wr(aaso_pkg::OFS_FILE_SEL, 32'h5, OK);
      foreach (rows[i]) begin
         wr(aaso_pkg::OFS_ACC, {24'h0, rows[i].acc}, OK);
         wr(aaso_pkg::OFS_STATUS, {29'h0, rows[i].flg}, OK);
         wr(aaso_pkg::OFS_FILE_DATA, {24'h0, rows[i].fv}, OK);
         wr(aaso_pkg::OFS_CMD, rows[i].cmd, OK);
         rdx(aaso_pkg::OFS_ACC, {24'h0, rows[i].eacc}, OK);
         rdx(aaso_pkg::OFS_STATUS, {29'h0, rows[i].eflg}, OK);
         rdx(aaso_pkg::OFS_FILE_DATA, {24'h0, rows[i].efile}, OK);
      end
      // Pointer add: wrap upward, flags untouched
      wr(aaso_pkg::OFS_PTR0, 32'hFFFF, OK);
      wr(aaso_pkg::OFS_STATUS, 32'h7, OK);
      wr(aaso_pkg::OFS_CMD, 32'h00010001, OK);
      rdx(aaso_pkg::OFS_PTR0, 32'h0000, OK);
      rdx(aaso_pkg::OFS_STATUS, 32'h7, OK);
      // Pointer add on the second pointer: wrap downward
      wr(aaso_pkg::OFS_PTR1, 32'h0000, OK);
      wr(aaso_pkg::OFS_CMD, 32'h003F0021, OK);
      rdx(aaso_pkg::OFS_PTR1, 32'hFFFF, OK);
      rdx(aaso_pkg::OFS_PTR0, 32'h0000, OK);
      // Literal range ends and ignored upper literal bits
      wr(aaso_pkg::OFS_PTR1, 32'h1000, OK);
      wr(aaso_pkg::OFS_CMD, 32'h00200021, OK);
      rdx(aaso_pkg::OFS_PTR1, 32'h0FE0, OK);
      wr(aaso_pkg::OFS_CMD, 32'h001F0021, OK);
      rdx(aaso_pkg::OFS_PTR1, 32'h0FFF, OK);
      wr(aaso_pkg::OFS_CMD, 32'h00FF0021, OK);
      rdx(aaso_pkg::OFS_PTR1, 32'h0FFE, OK);
      // Byte strobes: only the op byte of the command is replaced
      wstrb <= 4'h1;
      wr(aaso_pkg::OFS_CMD, 32'h00000021, OK);
      wstrb <= 4'hF;
      rdx(aaso_pkg::OFS_PTR1, 32'h0FFD, OK);
      rdx(aaso_pkg::OFS_CMD, 32'h00FF0021, OK);
      // Unmapped and misaligned places
      rdx(8'h1C, 32'h0, ER);
      rdx(8'h05, 32'h0, ER);
      wr(8'h1C, 32'h12, ER);
      // Clock enable low: readies drop, a write waits for it
      ce <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk({29'h0, awready, wready, arready}, 32'h0);
      fork
         wr(aaso_pkg::OFS_ACC, 32'h5A, OK);
         begin
            repeat (3) @(posedge clk_sys);
            chk({31'h0, bvalid}, 32'h0);
            ce <= 1'b1;
         end
      join
      rdx(aaso_pkg::OFS_ACC, 32'h5A, OK);
      // Second reset in mid-run
      wr(aaso_pkg::OFS_ACC, 32'hAA, OK);
      do_reset();
      rdx(aaso_pkg::OFS_ACC, 32'h0, OK);
      rdx(aaso_pkg::OFS_PTR1, 32'h0, OK);
      rdx(aaso_pkg::OFS_CMD, 32'h0, OK);
      end_sim();
   end
endmodule
`default_nettype wire
